/* design/drm_pkg.sv */
// shared constants and types of the dual bus register multiplexer
package drm_pkg;

  // ********************************
  // widths, reset values, enable and select levels
  // ********************************
  localparam int DRM_WIDTH = 8;
  localparam int DRM_BANKS = 2;
  localparam logic [DRM_WIDTH-1:0] DRM_DATA_RST = 8'h00;
  localparam logic DRM_OE_OFF = 1'h1;
  localparam logic DRM_OE_ON = 1'h0;
  localparam logic DRM_SEL_SECOND = 1'h0;
  localparam logic DRM_SEL_FIRST = 1'h1;

  // ********************************
  // output pin group
  // ********************************
  typedef struct packed {
    logic [DRM_WIDTH-1:0] data;
    logic oe_n;
  } drm_out_t;

endpackage

/* design/drm_bank.sv */
// one edge-loaded register bank of the multiplexer
`timescale 1ns/100ps
`default_nettype none

module drm_bank
  import drm_pkg::*;
#(
  parameter int W = DRM_WIDTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // load strobe and data
  input wire logic i_load,
  input wire logic [W-1:0] i_data,
  // stored value and its next value
  output logic [W-1:0] o_next,
  output logic [W-1:0] o_q
);

  logic [W-1:0] q;

  always_comb begin
    o_next = i_load ? i_data : q;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      q <= W'(DRM_DATA_RST);
    end else begin
      q <= o_next;
    end
  end

  assign o_q = q;

endmodule

`default_nettype wire

/* design/drm_mux.sv */
// top of the dual bus register multiplexer
// How it works
// - load edge captures both buses together
// - sixteen storage bits, eight per bus
// - load pin low: outputs high impedance
// - load pin high: outputs driven
// - select low shows second bank
// - select high shows first bank
// - each output bit picks one of two
`timescale 1ns/100ps
`default_nettype none

module drm_mux
  import drm_pkg::*;
#(
  parameter int W = DRM_WIDTH
) (
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // device clock pin and select
  input wire logic i_load_clk,
  input wire logic i_bus_select,
  // data buses
  input wire logic [W-1:0] i_first_bus_inputs,
  input wire logic [W-1:0] i_second_bus_inputs,
  // multiplexed output bus
  output logic [W-1:0] o_mux_outputs,
  output logic o_mux_outputs_oe_n
);

  // ********************************
  // load edge detect
  // ********************************
  // the detector idles low like the pin, so reset release makes no false edge
  logic load_prev;
  logic next_load_prev;
  logic load_edge;

  always_comb begin
    next_load_prev = i_load_clk;
    load_edge = i_load_clk & ~load_prev;
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      load_prev <= 1'h0;
    end else begin
      load_prev <= next_load_prev;
    end
  end

  // ********************************
  // register banks
  // ********************************
  // eight flops per bank, sixteen in all
  logic [W-1:0] bank_a;
  logic [W-1:0] bank_b;
  logic [W-1:0] next_bank_a;
  logic [W-1:0] next_bank_b;

  // both banks share one strobe so the pair always loads together
  drm_bank #(.W(W)) u_bank_first (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_load(load_edge),
    .i_data(i_first_bus_inputs),
    .o_next(next_bank_a),
    .o_q(bank_a)
  );

  drm_bank #(.W(W)) u_bank_second (
    .i_clk_sys(i_clk_sys),
    .i_resetn(i_resetn),
    .i_load(load_edge),
    .i_data(i_second_bus_inputs),
    .o_next(next_bank_b),
    .o_q(bank_b)
  );

  // ********************************
  // output stage
  // ********************************
  // limitation: the drivers follow the load pin one system clock late,
  // the price of keeping every output on a flop
  drm_out_t out_q;
  drm_out_t next_out;

  // next bank values feed the mux so freshly loaded data shows at once;
  // the select is read every cycle while the load pin is high, not only at a load edge
  always_comb begin
    next_out.oe_n = i_load_clk ? DRM_OE_ON : DRM_OE_OFF;
    next_out.data = out_q.data;
    if (i_load_clk) begin
      for (int i = 0; i < W; i++) begin
        next_out.data[i] = (i_bus_select == DRM_SEL_FIRST) ?
          next_bank_a[i] : next_bank_b[i];
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      out_q.oe_n <= DRM_OE_OFF;
      out_q.data <= W'(DRM_DATA_RST);
    end else begin
      out_q <= next_out;
    end
  end

  assign o_mux_outputs = out_q.data;
  assign o_mux_outputs_oe_n = out_q.oe_n;

  // ********************************
  // checks
  // ********************************
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);

  a_first_bank_load: assert property (
    i_load_clk && !load_prev |=> bank_a == $past(i_first_bus_inputs))
    else $error("first bank missed load");

  a_second_bank_load: assert property (
    i_load_clk && !load_prev |=> bank_b == $past(i_second_bus_inputs))
    else $error("second bank missed load");

  a_banks_hold: assert property (
    !(i_load_clk && !load_prev) |=> $stable(bank_a) && $stable(bank_b))
    else $error("bank changed without load edge");

  a_low_tristate: assert property (
    !i_load_clk |=> o_mux_outputs_oe_n)
    else $error("outputs driven while load pin low");

  a_high_drives: assert property (
    i_load_clk |=> !o_mux_outputs_oe_n)
    else $error("outputs not driven while load pin high");

  a_second_shown: assert property (
    i_load_clk && !i_bus_select |=> o_mux_outputs == bank_b)
    else $error("second bank not shown");

  a_first_shown: assert property (
    i_load_clk && i_bus_select |=> o_mux_outputs == bank_a)
    else $error("first bank not shown");

  a_bitwise_pick: assert property (
    !o_mux_outputs_oe_n |-> ((o_mux_outputs ^ bank_a) & (o_mux_outputs ^ bank_b)) == '0)
    else $error("output bit matches neither bank");

  a_select_acts: assert property (
    i_load_clk && load_prev && $changed(i_bus_select) && $past(i_load_clk)
      |=> (bank_a == bank_b) || $changed(o_mux_outputs))
    else $error("select change did not reach outputs");

  // ********************************
  // cycle exact checks
  // ********************************

  // a mux that shows the right bank one cycle late already fails a_first_shown or a_second_shown at a load edge;
  // these pin the answer to the bus inputs sampled on the edge that loads the banks
  a_new_first_shown: assert property (
    i_load_clk && !load_prev && i_bus_select |=> o_mux_outputs == $past(i_first_bus_inputs))
    else $error("freshly loaded first bank not shown");

  a_new_second_shown: assert property (
    i_load_clk && !load_prev && !i_bus_select
      |=> o_mux_outputs == $past(i_second_bus_inputs))
    else $error("freshly loaded second bank not shown");

  a_edge_history: assert property (
    $past(i_resetn) |-> load_prev == $past(i_load_clk))
    else $error("load edge detector lost a sample");

  a_edge_pulse: assert property (
    load_edge |=> !load_edge)
    else $error("load edge lasted more than one cycle");

  a_steady_drive: assert property (
    $past(i_resetn) && i_load_clk && $past(i_load_clk) |-> !o_mux_outputs_oe_n)
    else $error("outputs off although load pin stayed high");

  a_steady_off: assert property (
    $past(i_resetn) && !i_load_clk && !$past(i_load_clk) |-> o_mux_outputs_oe_n)
    else $error("outputs on although load pin stayed low");

  // parked data means nothing at the pins, but holding it keeps the
  // output flops quiet while the bus belongs to someone else
  a_disabled_hold: assert property (
    !i_load_clk |=> $stable(o_mux_outputs))
    else $error("parked output data moved");

  a_banks_pair: assert property (
    $past(i_resetn) && ($changed(bank_a) || $changed(bank_b)) |-> $past(load_edge))
    else $error("bank moved without a load edge");

  // reset is our addition, the bare part has none; it parks the outputs
  // and clears both banks, so it is checked while reset itself is low
  a_reset_clears: assert property (
    disable iff (1'b0)
    !i_resetn |=> o_mux_outputs_oe_n && o_mux_outputs == W'(DRM_DATA_RST) &&
      bank_a == W'(DRM_DATA_RST) && bank_b == W'(DRM_DATA_RST))
    else $error("reset left state behind");

  // ********************************
  // lane checks
  // ********************************

  // one assertion per lane, so a fault in a single bit names its lane
  for (genvar b = 0; b < W; b++) begin : g_lane
    a_lane_pick: assert property (
      @(posedge i_clk_sys) disable iff (!i_resetn)
      i_load_clk && load_prev |=>
        o_mux_outputs[b] == (($past(i_bus_select) == DRM_SEL_FIRST) ? bank_a[b] : bank_b[b]))
      else $error("output lane shows the wrong bank");
  end

endmodule

`default_nettype wire

/* tb/drm_host_model.sv */
// host model: loads a row and column pair, then steps the select
`timescale 1ns/100ps
`default_nettype none
module drm_host_model
  import drm_pkg::*;
(
  // clock and reset
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // command from the bench
  input wire logic i_go,
  input wire logic i_start_sel,
  input wire logic [DRM_WIDTH-1:0] i_row,
  input wire logic [DRM_WIDTH-1:0] i_col,
  // device pins
  output logic o_load_clk,
  output logic o_sel,
  output logic [DRM_WIDTH-1:0] o_first,
  output logic [DRM_WIDTH-1:0] o_second
);
  logic [1:0] st;
  always @(posedge i_clk_sys) begin
    if (!i_resetn) begin
      o_load_clk <= 1'b0;
      o_sel <= DRM_SEL_FIRST;
      o_first <= DRM_DATA_RST;
      o_second <= DRM_DATA_RST;
      st <= 2'h0;
    end else if (i_go && st == 2'h0) begin
      o_load_clk <= 1'b1;
      o_first <= i_row;
      o_second <= i_col;
      o_sel <= i_start_sel;
      st <= 2'h1;
    end else if (st == 2'h1) begin
      // buses released: inverse levels so stale data cannot pass
      o_first <= ~o_first;
      o_second <= ~o_second;
      o_sel <= ~o_sel;
      st <= 2'h2;
    end else if (st == 2'h2) begin
      o_load_clk <= 1'b0;
      st <= 2'h0;
    end
  end
endmodule
`default_nettype wire

/* tb/drm_mux_bench.sv */
// self-checking bench of the dual bus register multiplexer
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin mismatches++; \
  $display("MISMATCH %0t output differs", $time); end end
module drm_mux_bench import drm_pkg::*;;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic go = 1'b0;
  logic first_sel = DRM_SEL_FIRST;
  logic [7:0] row = 8'h00;
  logic [7:0] col = 8'h00;
  logic ld, sel, oe_n;
  logic [7:0] fa, fb, y;
  int mismatches = 0;
  int compares = 0;
  int cycles = 0;
  drm_host_model host (.i_clk_sys(clk), .i_resetn(rstn), .i_go(go),
    .i_start_sel(first_sel), .i_row(row), .i_col(col),
    .o_load_clk(ld), .o_sel(sel), .o_first(fa), .o_second(fb));
  drm_mux dut (.i_clk_sys(clk), .i_resetn(rstn), .i_load_clk(ld), .i_bus_select(sel),
    .i_first_bus_inputs(fa), .i_second_bus_inputs(fb), .o_mux_outputs(y),
    .o_mux_outputs_oe_n(oe_n));
  initial begin
    forever #2.5 clk = ~clk;
  end
  // whole run needs about 30 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 200) begin
      mismatches++;
      results();
    end
  end
  task results();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // host loads one edge after go; the device shows the new bank on the edge after that
  task run(input logic [7:0] r, input logic [7:0] c, input logic s);
    @(posedge clk);
    row <= r;
    col <= c;
    first_sel <= s;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    `CHK(y, (s == DRM_SEL_FIRST) ? r : c)
    `CHK(oe_n, DRM_OE_ON)
    @(posedge clk);
    #1;
    `CHK(y, (s == DRM_SEL_FIRST) ? c : r)
    `CHK(oe_n, DRM_OE_ON)
    @(posedge clk);
    #1;
    `CHK(oe_n, DRM_OE_OFF)
    `CHK(y, (s == DRM_SEL_FIRST) ? c : r)
  endtask
  task t_pair();
    run(8'h5a, 8'ha5, DRM_SEL_FIRST);
    $display("t_pair done");
  endtask
  task t_bits();
    run(8'h0f, 8'hf0, DRM_SEL_SECOND);
    $display("t_bits done");
  endtask
  task t_reset();
    run(8'h3c, 8'hc3, DRM_SEL_FIRST);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(oe_n, DRM_OE_OFF)
    `CHK(y, DRM_DATA_RST)
    run(8'h81, 8'h18, DRM_SEL_FIRST);
    $display("t_reset done");
  endtask
  initial begin
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    #1;
    `CHK(oe_n, DRM_OE_OFF)
    `CHK(y, DRM_DATA_RST)
    t_pair();
    t_bits();
    t_reset();
    results();
  end
endmodule
`default_nettype wire
